// [sis_cfg.svh]
// Register map, field positions and reset values of the sensor
// interrupt status and modulator timing block.
// Assumes the includer uses 8-bit register addresses and 8-bit data.
`ifndef SIS_CFG_SVH
`define SIS_CFG_SVH

`define SIS_ADDR_FLAGS        8'h8E
`define SIS_ADDR_MOD_TIMING   8'h8F
`define SIS_ADDR_AMB_IR       8'h90
`define SIS_ADDR_CTRL         8'hE0

`define SIS_BIT_BS_READY      0
`define SIS_BIT_AMB_READY     1
`define SIS_BIT_BELOW         2
`define SIS_BIT_ABOVE         3
`define SIS_FLAG_MASK         8'h0F

`define SIS_MOD_DELAY_HI      7
`define SIS_MOD_DELAY_LO      5
`define SIS_MOD_FREQ_HI       4
`define SIS_MOD_FREQ_LO       3
`define SIS_MOD_DEAD_HI       2
`define SIS_MOD_DEAD_LO       0
`define SIS_MOD_TIMING_RST    8'h01

`define SIS_CTRL_RST          8'h00
`define SIS_CTRL_PERSIST_HI   6
`define SIS_CTRL_PERSIST_LO   4
`define SIS_CTRL_BS_EN        3
`define SIS_CTRL_AMB_EN       2
`define SIS_CTRL_LIM_EN       1
`define SIS_CTRL_LIM_SEL      0

`define SIS_AMB_IR_RST        8'h00

`endif

// [sis_pkg.sv]
// Types shared by the sensor interrupt status block.
// Assumes nothing of its surroundings.
package sis_pkg;
	typedef enum logic [2:0]
	{
		SIS_ST_STANDBY = 3'b001,
		SIS_ST_MEASURE = 3'b010,
		SIS_ST_REPORT  = 3'b100
	} sis_state_t;
endpackage : sis_pkg

// [sis_persist.sv]
// Persistence counter for one limit comparison.
// Assumes one result strobe per measurement, on the same clock.
`timescale 1ns/1ps
`include "sis_cfg.svh"
module sis_persist
	import sis_pkg::*;
#(
	parameter int CW = 8
)
(
	input  wire logic          clk_sys,
	input  wire logic          rst,
	input  wire logic          ce,
	input  wire logic          sample,
	input  wire logic          out_of_range,
	input  wire logic [2:0]    persist_code,
	output logic               fire
);
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic [CW-1:0] need;

	// The needed count doubles per code; saturating stops refiring on long runs.
	always_comb
	begin
		need  = CW'(1) << persist_code;
		cnt_d = cnt_q;
		fire  = 1'b0;
		if (sample)
		begin
			if (!out_of_range)
				cnt_d = '0;
			else if (cnt_q < need)
			begin
				cnt_d = cnt_q + CW'(1);
				fire  = (cnt_q + CW'(1)) == need;
			end
		end
	end

	// Counter register.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			cnt_q <= '0;
		else if (ce)
			cnt_q <= cnt_d;
	end
endmodule : sis_persist

// [sis_irq_status.sv]
// Interrupt status flags, modulator timing register and standby control.
// Assumes a register port already decoded from the serial bus on clk_sys,
// and measurement results that arrive as one-cycle strobes on clk_sys.
//
// Notes on behaviour
// - Status register lives at 8Eh.
// - Below low limit sets below flag.
// - Above high limit sets above flag.
// - Flags stay latched until host clears.
// - Writing one clears; zero leaves flag.
// - Interrupt pin low while any flag set.
// - Delay field at 8Fh, resets zero.
// - Two-bit frequency field, reset 390.625 kHz.
// - Dead-time field resets to one.
// - Idle means standby, only registers active.
// - Standby keeps emitter sink disabled.
// - Register port works during standby.
// - Ready and limit interrupts need enables.
// - Select bit routes limit compare source.
// - Persistence needs 1 to 128 hits.
// - Ambient enable gates ambient ready flag.
`timescale 1ns/1ps
`include "sis_cfg.svh"
module sis_irq_status
	import sis_pkg::*;
#(
	parameter int DW = 16
)
(
	input  wire logic          clk_sys,
	input  wire logic          rst,
	input  wire logic          ce,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	input  wire logic [7:0]    reg_addr,
	input  wire logic [7:0]    reg_wdata,
	output logic      [7:0]    reg_rdata,
	input  wire logic          meas_request,
	input  wire logic          bs_result_valid,
	input  wire logic [DW-1:0] bs_result,
	input  wire logic          amb_result_valid,
	input  wire logic [DW-1:0] amb_result,
	input  wire logic [DW-1:0] low_limit,
	input  wire logic [DW-1:0] high_limit,
	output logic               int_n_o,
	output logic               int_n_oe,
	output logic      [2:0]    mod_delay,
	output logic      [1:0]    test_signal_frequency,
	output logic      [2:0]    mod_dead_time,
	output logic               emitter_sink_enable,
	output logic               measure_active
);
	logic [3:0]  flags_q, flags_d;
	logic [7:0]  mod_q, mod_d;
	logic [7:0]  ctrl_q, ctrl_d;
	logic [7:0]  rdata_q, rdata_d;
	sis_state_t  st_q, st_d;
	logic        lim_sample;
	logic [DW-1:0] lim_value;
	logic        below_fire, above_fire;
	logic        wr_flags, wr_mod, wr_ctrl;
	logic        biosensor_ready_irq_enable, amb_ready_irq_enable;
	logic        limit_irq_enable, limit_source_select;
	logic [3:0]  set_ev;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		hit = (a == b);
	endfunction : hit

	assign wr_flags = reg_wr && hit(reg_addr, `SIS_ADDR_FLAGS);
	assign wr_mod   = reg_wr && hit(reg_addr, `SIS_ADDR_MOD_TIMING);
	assign wr_ctrl  = reg_wr && hit(reg_addr, `SIS_ADDR_CTRL);
	assign biosensor_ready_irq_enable = ctrl_q[`SIS_CTRL_BS_EN];
	assign amb_ready_irq_enable       = ctrl_q[`SIS_CTRL_AMB_EN];
	assign limit_irq_enable           = ctrl_q[`SIS_CTRL_LIM_EN];
	assign limit_source_select        = ctrl_q[`SIS_CTRL_LIM_SEL];

	// Limit comparison routed to one source.
	assign lim_sample = limit_source_select ? amb_result_valid : bs_result_valid;
	assign lim_value  = limit_source_select ? amb_result : bs_result;

	sis_persist #(.CW(8)) u_below
	(
		.clk_sys      (clk_sys),
		.rst          (rst),
		.ce           (ce),
		.sample       (lim_sample),
		.out_of_range (lim_value < low_limit),
		.persist_code (ctrl_q[`SIS_CTRL_PERSIST_HI:`SIS_CTRL_PERSIST_LO]),
		.fire         (below_fire)
	);

	sis_persist #(.CW(8)) u_above
	(
		.clk_sys      (clk_sys),
		.rst          (rst),
		.ce           (ce),
		.sample       (lim_sample),
		.out_of_range (lim_value > high_limit),
		.persist_code (ctrl_q[`SIS_CTRL_PERSIST_HI:`SIS_CTRL_PERSIST_LO]),
		.fire         (above_fire)
	);

	// Events that raise flags, each gated by its enable.
	always_comb
	begin
		set_ev = 4'h0;
		set_ev[`SIS_BIT_BS_READY]  = bs_result_valid && biosensor_ready_irq_enable;
		set_ev[`SIS_BIT_AMB_READY] = amb_result_valid && amb_ready_irq_enable;
		set_ev[`SIS_BIT_BELOW]     = below_fire && limit_irq_enable;
		set_ev[`SIS_BIT_ABOVE]     = above_fire && limit_irq_enable;
	end

	// Register next values; a set in the clear cycle wins so no event is lost.
	always_comb
	begin
		flags_d = flags_q;
		mod_d   = mod_q;
		ctrl_d  = ctrl_q;
		if (wr_flags)
			flags_d = flags_q & ~reg_wdata[3:0];
		flags_d = flags_d | set_ev;
		if (wr_mod)
			mod_d = reg_wdata;
		if (wr_ctrl)
			ctrl_d = {1'b0, reg_wdata[6:0]};
	end

	// Read data; the reserved ambient level reads its reset value.
	always_comb
	begin
		rdata_d = rdata_q;
		if (reg_rd)
		begin
			case (reg_addr)
				`SIS_ADDR_FLAGS:      rdata_d = {4'h0, flags_q};
				`SIS_ADDR_MOD_TIMING: rdata_d = mod_q;
				`SIS_ADDR_AMB_IR:     rdata_d = `SIS_AMB_IR_RST;
				`SIS_ADDR_CTRL:       rdata_d = ctrl_q;
				default:              rdata_d = 8'h00;
			endcase
		end
	end

	// Standby until a measurement is demanded; a started one runs to its result. The register port never stops.
	always_comb
	begin
		case (st_q)
			SIS_ST_STANDBY: st_d = meas_request ? SIS_ST_MEASURE : SIS_ST_STANDBY;
			SIS_ST_MEASURE: st_d = (bs_result_valid || amb_result_valid) ?
				SIS_ST_REPORT : SIS_ST_MEASURE;
			SIS_ST_REPORT:  st_d = meas_request ? SIS_ST_MEASURE : SIS_ST_STANDBY;
			default:        st_d = SIS_ST_STANDBY;
		endcase
	end

	// State registers; the register path is clocked the same in every mode.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			flags_q <= 4'h0;
			mod_q   <= `SIS_MOD_TIMING_RST;
			ctrl_q  <= `SIS_CTRL_RST;
			rdata_q <= 8'h00;
			st_q    <= SIS_ST_STANDBY;
		end
		else if (ce)
		begin
			flags_q <= flags_d;
			mod_q   <= mod_d;
			ctrl_q  <= ctrl_d;
			rdata_q <= rdata_d;
			st_q    <= st_d;
		end
	end

	assign reg_rdata             = rdata_q;
	assign mod_delay             = mod_q[`SIS_MOD_DELAY_HI:`SIS_MOD_DELAY_LO];
	assign test_signal_frequency = mod_q[`SIS_MOD_FREQ_HI:`SIS_MOD_FREQ_LO];
	assign mod_dead_time         = mod_q[`SIS_MOD_DEAD_HI:`SIS_MOD_DEAD_LO];
	assign measure_active        = (st_q == SIS_ST_MEASURE);
	// Emitter sink off in standby whatever current is programmed.
	assign emitter_sink_enable   = (st_q == SIS_ST_MEASURE);
	// Open drain: output data is always low, enable low means pulling down.
	assign int_n_o  = 1'b0;
	assign int_n_oe = ~(|flags_q);

	a_flag_sticky: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && $past(ce) && $past(flags_q[0]) && !$past(wr_flags)) |-> flags_q[0])
		else $error("Flag dropped without a clear.");
	a_clear_one: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && wr_flags && reg_wdata[2] && !set_ev[2]) |=> !flags_q[2])
		else $error("Write one did not clear.");
	a_set_wins: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && set_ev[3]) |=> flags_q[3])
		else $error("Event lost.");
	a_pin_level: assert property (@(posedge clk_sys) disable iff (rst)
		!int_n_o && (int_n_oe == (flags_q == 4'h0)))
		else $error("Interrupt pin mismatch.");
	a_bs_gate: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && $past(ce) && !$past(flags_q[0]) && !$past(biosensor_ready_irq_enable))
		|-> !flags_q[0])
		else $error("Ungated biosensor flag.");
	a_amb_gate: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && amb_result_valid && amb_ready_irq_enable) |=> flags_q[1])
		else $error("Ambient ready missed.");
	a_standby_sink: assert property (@(posedge clk_sys) disable iff (rst)
		($past(st_q) == SIS_ST_STANDBY && !$past(meas_request)) |-> !emitter_sink_enable)
		else $error("Sink on in standby.");
	a_flag_read: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && reg_rd && reg_addr == `SIS_ADDR_FLAGS) |=> reg_rdata[7:4] == 4'h0)
		else $error("Upper status bits not zero.");
	a_mod_write: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && wr_mod) |=> mod_q == $past(reg_wdata))
		else $error("Timing write lost.");
	c_clear: cover property (@(posedge clk_sys) disable iff (rst) wr_flags && flags_q != 4'h0);
	c_above: cover property (@(posedge clk_sys) disable iff (rst) set_ev[3]);
	c_below: cover property (@(posedge clk_sys) disable iff (rst) set_ev[2]);
	c_measure: cover property (@(posedge clk_sys) disable iff (rst) st_q == SIS_ST_REPORT);
endmodule : sis_irq_status

// [sis_host_model.sv]
// Host side of the register port: single-byte writes and reads.
// Assumes the already-decoded strobe port of the status block on clk_sys.
`timescale 1ns/1ps
module sis_host_model
(
	input  wire logic       clk_sys,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic [7:0]      reg_addr,
	output logic [7:0]      reg_wdata,
	input  wire logic [7:0] reg_rdata
);
	// Idle bus; this host never addresses the reserved level register.
	initial
	begin
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 8'h00;
		reg_wdata = 8'h00;
	end

	// Released address and data are inverted so stale values never pass.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
		reg_addr  <= ~a;
		reg_wdata <= ~d;
		#1;
	endtask : wr

	// Read data is registered, so it is taken just after the strobe edge.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
	endtask : rd
endmodule : sis_host_model

// [sensor_irq_status_and_modulator_cfg_tb.sv]
// Self-checking bench of the interrupt status and modulator timing block.
// Assumes the host model for register traffic and a 100 MHz clock.
`timescale 1ns/1ps
module sensor_irq_status_and_modulator_cfg_tb;
	logic        clk_sys   = 1'b0;
	logic        rst       = 1'b1;
	logic        meas      = 1'b0;
	logic        ce        = 1'b1;
	logic        act;
	logic        bs_valid  = 1'b0;
	logic        amb_valid = 1'b0;
	logic [15:0] res       = 16'h0000;
	logic        reg_wr, reg_rd, int_n_o, int_n_oe, sink;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd_val;
	logic [2:0]  delay, dead;
	logic [1:0]  freq;
	int          n_fail  = 0;
	int          n_tests = 0;

	// Free-running system clock.
	always #5 clk_sys = ~clk_sys;

	sis_host_model i_sis_host_model (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

	// Limits are fixed at 100 and 200; the timing test drops the clock enable once.
	sis_irq_status i_sis_irq_status (.clk_sys(clk_sys), .rst(rst), .ce(ce),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .meas_request(meas), .bs_result_valid(bs_valid),
		.bs_result(res), .amb_result_valid(amb_valid), .amb_result(res),
		.low_limit(16'h0064), .high_limit(16'h00C8), .int_n_o(int_n_o),
		.int_n_oe(int_n_oe), .mod_delay(delay), .test_signal_frequency(freq),
		.mod_dead_time(dead), .emitter_sink_enable(sink), .measure_active(act));

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
		i_sis_host_model.rd(a, rd_val);
		chk(what, rd_val, exp);
	endtask : rdchk

	// One result strobe; the same value feeds both sources, the strobe picks one.
	task automatic pulse(input logic amb, input logic [15:0] v);
		@(posedge clk_sys);
		bs_valid  <= ~amb;
		amb_valid <= amb;
		res       <= v;
		@(posedge clk_sys);
		bs_valid  <= 1'b0;
		amb_valid <= 1'b0;
	endtask : pulse

	// Bounded wait for the emitter sink; running out ends the run.
	task automatic wait_sink(input logic v);
		for (int i = 0; i < 8 && sink !== v; i++)
			@(posedge clk_sys) #1;
		chk("emitter_sink_enable", {7'h00, sink}, {7'h00, v});
		chk("measure_active", {7'h00, act}, {7'h00, v});
		if (sink !== v)
			end_of_test();
	endtask : wait_sink

	task automatic t_reset;
		rdchk(8'h8F, 8'h01, "timing reset");
		rdchk(8'h8E, 8'h00, "flags reset");
		rdchk(8'hE1, 8'h00, "unmapped read");
		chk("int_n_oe", {7'h00, int_n_oe}, 8'h01);
		chk("int_n_o", {7'h00, int_n_o}, 8'h00);
		wait_sink(1'b0);
		$display("test reset done");
	endtask : t_reset

	// Every frequency code, with delay and dead time at other than reset.
	task automatic t_timing;
		for (int f = 0; f < 4; f++)
		begin
			i_sis_host_model.wr(8'h8F, {3'd5, f[1:0], 3'd2});
			chk("mod_delay", {5'h00, delay}, 8'h05);
			chk("frequency", {6'h00, freq}, {6'h00, f[1:0]});
			chk("dead_time", {5'h00, dead}, 8'h02);
		end
		// A write while the clock enable is low must leave delay and frequency frozen.
		@(posedge clk_sys);
		ce <= 1'b0;
		i_sis_host_model.wr(8'h8F, 8'h01);
		chk("frozen delay", {5'h00, delay}, 8'h05);
		chk("frozen frequency", {6'h00, freq}, 8'h03);
		@(posedge clk_sys);
		ce <= 1'b1;
		i_sis_host_model.wr(8'h8F, 8'h01);
		rdchk(8'h8F, 8'h01, "timing");
		$display("test timing done");
	endtask : t_timing

	task automatic t_ready;
		i_sis_host_model.wr(8'hE0, 8'h0C);
		@(posedge clk_sys);
		meas <= 1'b1;
		wait_sink(1'b1);
		pulse(1'b0, 16'h0096);
		rdchk(8'h8E, 8'h01, "bs ready");
		chk("int_n_oe", {7'h00, int_n_oe}, 8'h00);
		pulse(1'b1, 16'h0096);
		rdchk(8'h8E, 8'h03, "amb ready");
		i_sis_host_model.wr(8'h8E, 8'hF0);
		rdchk(8'h8E, 8'h03, "zero write");
		i_sis_host_model.wr(8'h8E, 8'h01);
		rdchk(8'h8E, 8'h02, "one clear");
		i_sis_host_model.wr(8'h8E, 8'h02);
		chk("int_n_oe", {7'h00, int_n_oe}, 8'h01);
		$display("test ready done");
	endtask : t_ready

	// Persistence of two samples; the in-range sample restarts the count.
	task automatic t_limit;
		// Ambient source, persistence one, both enables off: nothing may latch.
		i_sis_host_model.wr(8'hE0, 8'h01);
		pulse(1'b1, 16'h012C);
		rdchk(8'h8E, 8'h00, "disabled");
		i_sis_host_model.wr(8'hE0, 8'h12);
		pulse(1'b0, 16'h0032);
		rdchk(8'h8E, 8'h00, "one below");
		pulse(1'b0, 16'h0032);
		rdchk(8'h8E, 8'h04, "below");
		i_sis_host_model.wr(8'h8E, 8'h04);
		pulse(1'b0, 16'h0096);
		i_sis_host_model.wr(8'hE0, 8'h13);
		pulse(1'b1, 16'h012C);
		pulse(1'b1, 16'h012C);
		rdchk(8'h8E, 8'h08, "above");
		// The running measurement ends only with its result, then standby follows.
		@(posedge clk_sys);
		meas <= 1'b0;
		@(posedge clk_sys) #1;
		chk("sink held", {7'h00, sink}, 8'h01);
		pulse(1'b0, 16'h0096);
		wait_sink(1'b0);
		$display("test limit done");
	endtask : t_limit

	initial
	begin
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		t_reset();
		t_timing();
		t_ready();
		t_limit();
		end_of_test();
	end
endmodule : sensor_irq_status_and_modulator_cfg_tb
